// ===== dv/cpt_config_sva.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checker for the protection configuration block
// ------------------------------------------------------------
module cpt_config_sva (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        frame_start_i,
  input wire logic        line_end_i,
  input wire logic        master_activity_i,
  input wire logic        prot_master_bus_free_o,
  input wire logic        av_mute_o,
  input wire logic        encrypt_o,
  input wire logic        blue_screen_o,
  input wire logic        auth_tick_o,
  input wire logic        checksum_valid_o,
  input wire logic        ri_check_o,
  input wire logic        ri_sync_check_o,
  input wire logic        pj_check_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held beyond one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered after one cycle");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  ri_frame_a: assert property ((ri_check_o || ri_sync_check_o) |->
    $past(frame_start_i) && !(ri_check_o && ri_sync_check_o))
    else $error("link value check out of frame step");
  pj_frame_a: assert property (pj_check_o |-> $past(frame_start_i))
    else $error("pj check without frame start");
  sum_line_a: assert property (checksum_valid_o |-> $past(line_end_i))
    else $error("checksum without line end");
  blue_enc_a: assert property (!(blue_screen_o && encrypt_o))
    else $error("blue screen while encrypting");
  mute_hold_a: assert property (av_mute_o && $past(av_mute_o) |->
    $stable({encrypt_o, blue_screen_o}))
    else $error("encryption outputs moved during mute");
  bus_busy_a: assert property (master_activity_i |-> ##2 !prot_master_bus_free_o)
    else $error("bus free during signalling");
  tick_pulse_a: assert property (auth_tick_o |=> !auth_tick_o)
    else $error("timer tick longer than one cycle");
endmodule

// ===== dv/cpt_config_tb_top.sv
`timescale 1ns/1ps
module cpt_config_tb_top;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, strap_repeater_i;
  logic        authenticated_i, frame_start_i, in_band_encrypt_i, pixel_valid_i;
  logic        line_end_i, wait_start_i, master_activity_i, rx_detect_i, rx_lock_i;
  logic        wb_ack_o, irq_o, prot_master_fast_timing_o, prot_master_bus_free_o;
  logic        status_signalling_select_o, transmit_repeater_enable_o, av_mute_o;
  logic        encrypt_o, blue_screen_o, auth_tick_o, wait_done_o, checksum_valid_o;
  logic        ri_check_o, ri_sync_check_o, pj_check_o, present, locked, talk;
  logic [9:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [23:0] pixel_rgb_i, checksum_rgb_o;
  logic [7:0]  q;
  int          n_mismatch, samples_checked, cycles, n_ri, n_sy, n_pj, n;

  cpt_config #(.BUS_IDLE_CYC(50), .TICK_CYC(20)) cpt_config_i (.*);
  cpt_rx_model cpt_rx_model_i (.clk_i, .present_i(present), .locked_i(locked),
    .talk_i(talk), .rx_detect_o(rx_detect_i), .rx_lock_o(rx_lock_i),
    .activity_o(master_activity_i));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles++;
    n_ri += int'(ri_check_o);
    n_sy += int'(ri_sync_check_o);
    n_pj += int'(pj_check_o);
    if (cycles == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", what, e, g);
      n_mismatch++;
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int k;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'hF;
    wb_dat_i <= {24'h000000, d};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (k >= 20) cmp("ack", 1, 0);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00);
    cmp("register", {24'h0, e}, {24'h0, q});
  endtask

  task automatic do_reset(input logic s);
    @(posedge clk_i);
    strap_repeater_i <= s;
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic frames(input int f);
    n_ri = 0; n_sy = 0; n_pj = 0;
    repeat (f) begin
      @(posedge clk_i);
      frame_start_i <= 1'b1;
      @(posedge clk_i);
      frame_start_i <= 1'b0;
      @(posedge clk_i);
    end
    repeat (2) @(posedge clk_i);
  endtask

  task automatic pulse_wait_tick(output int g);
    g = 0;
    while (auth_tick_o !== 1'b1 && g < 300) begin @(posedge clk_i); g++; end
    g = 0;
    do begin @(posedge clk_i); g++; end while (auth_tick_o !== 1'b1 && g < 300);
  endtask

  function automatic logic [7:0] ocs(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[7:0] + {7'h00, s[8]};
  endfunction

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, strap_repeater_i, authenticated_i} = 6'h20;
    {frame_start_i, in_band_encrypt_i, pixel_valid_i, line_end_i} = 4'h0;
    {wait_start_i, present, locked, talk} = 4'h0;
    wb_adr_i = 10'h000; wb_sel_i = 4'h0; wb_dat_i = 32'h0; pixel_rgb_i = 24'h0;
    do_reset(1'b0);
    rd(cpt_pkg::IDX_DEBUG, 8'h00);
    rd(cpt_pkg::IDX_CONFIG, 8'h80);
    wb(1'b1, cpt_pkg::IDX_DEBUG, 8'hFF);
    rd(cpt_pkg::IDX_DEBUG, 8'h5F);
    cmp("fast", 1, prot_master_fast_timing_o);
    wb(1'b0, cpt_pkg::IDX_STATUS, 8'h00);
    cmp("status fast", 1, q[0]);
    rd(8'h10, 8'h00);
    wb(1'b1, cpt_pkg::IDX_DEBUG, 8'h04);
    frames(32);
    cmp("ri test", 2, n_ri);
    cmp("sync test", 2, n_sy);
    cmp("pj test", 16, n_pj);
    wb(1'b1, cpt_pkg::IDX_DEBUG, 8'h10);
    wb(1'b1, cpt_pkg::IDX_CONFIG, 8'h00);
    frames(256);
    cmp("ri", 2, n_ri);
    cmp("sync off", 0, n_sy);
    cmp("pj off", 0, n_pj);
    for (int on = 1; on >= 0; on--) begin
      wb(1'b1, cpt_pkg::IDX_DEBUG, on ? 8'h08 : 8'h00);
      @(posedge clk_i);
      pixel_valid_i <= 1'b1; pixel_rgb_i <= 24'hFF8001;
      @(posedge clk_i);
      pixel_rgb_i <= 24'h0190FF; line_end_i <= 1'b1;
      @(posedge clk_i);
      pixel_valid_i <= 1'b0; line_end_i <= 1'b0;
      @(posedge clk_i);
      cmp("sum valid", on, checksum_valid_o);
      if (on) cmp("sum", {~ocs(8'hFF, 8'h01), ~ocs(8'h80, 8'h90),
        ~ocs(8'h01, 8'hFF)}, checksum_rgb_o);
    end
    // Enable ends at zero before always-encrypt, so its read of one comes from the mode alone.
    for (int m = 0; m < 4; m++) for (int e = 1; e >= 0; e--) for (int a = 0; a < 2; a++) begin
      wb(1'b1, cpt_pkg::IDX_CONFIG, {3'b000, 2'(m), 3'b000});
      wb(1'b1, cpt_pkg::IDX_CTRL, 8'(e));
      authenticated_i <= a[0]; in_band_encrypt_i <= e[0];
      frames(1);
      cmp("encrypt", (m == 0 || m == 2) ? a[0] : e[0] & a[0], encrypt_o);
      if (m != 0) cmp("blue", m == 2 ? !a[0] : e[0] & !a[0], blue_screen_o);
      if (m == 2) rd(cpt_pkg::IDX_CTRL, 8'h01);
    end
    authenticated_i <= 1'b1;
    wb(1'b1, cpt_pkg::IDX_CONFIG, 8'h40);
    wb(1'b1, cpt_pkg::IDX_CONFIG, 8'h61);
    authenticated_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    cmp("muted", 7, {av_mute_o, encrypt_o, status_signalling_select_o});
    cmp("repeater", 1, transmit_repeater_enable_o);
    wb(1'b1, cpt_pkg::IDX_CONFIG, 8'h00);
    repeat (3) @(posedge clk_i);
    cmp("unmuted", 0, {encrypt_o, status_signalling_select_o});
    // Bus free and link check events are pending from earlier scenarios.
    wb(1'b1, cpt_pkg::IDX_IRQ_STAT, 8'h0F);
    for (int w = 0; w < 2; w++) begin
      wb(1'b1, cpt_pkg::IDX_CONFIG, w ? 8'h04 : 8'h00);
      @(posedge clk_i); wait_start_i <= 1'b1;
      @(posedge clk_i); wait_start_i <= 1'b0;
      n = 0;
      do begin @(posedge clk_i); n++; end while (wait_done_o !== 1'b1 && n < 3000);
      cmp("wait", 1, w ? (n >= 2000 && n < 2010) : n == 1);
    end
    rd(cpt_pkg::IDX_IRQ_STAT, 8'h04);
    cmp("irq masked", 0, irq_o);
    wb(1'b1, cpt_pkg::IDX_IRQ_MASK, 8'h05);
    @(posedge clk_i);
    cmp("irq on", 1, irq_o);
    wb(1'b1, cpt_pkg::IDX_IRQ_STAT, 8'h04);
    @(posedge clk_i);
    cmp("irq cleared", 0, irq_o);
    for (int s = 0; s < 2; s++) begin
      wb(1'b1, cpt_pkg::IDX_CONFIG, s ? 8'h02 : 8'h00);
      present <= 1'b1;
      repeat (4) @(posedge clk_i);
      cmp("detect", !s, irq_o);
      locked <= 1'b1;
      repeat (4) @(posedge clk_i);
      cmp("detect lock", 1, irq_o);
      wb(1'b1, cpt_pkg::IDX_IRQ_STAT, 8'h01);
      present <= 1'b0; locked <= 1'b0;
    end
    for (int d = 1; d >= 0; d--) begin
      wb(1'b1, cpt_pkg::IDX_DEBUG, d ? 8'h40 : 8'h00);
      talk <= 1'b1;
      @(posedge clk_i); talk <= 1'b0;
      repeat (80) @(posedge clk_i);
      cmp("bus free", !d, prot_master_bus_free_o);
    end
    pulse_wait_tick(n);
    cmp("tick", 20, n);
    wb(1'b1, cpt_pkg::IDX_DEBUG, 8'h02);
    pulse_wait_tick(n);
    pulse_wait_tick(n);
    cmp("fast tick", cpt_pkg::TICK_FAST_CYC, n);
    do_reset(1'b1);
    rd(cpt_pkg::IDX_CONFIG, 8'h98);
    end_of_test();
  end
endmodule

bind cpt_config cpt_config_sva cpt_config_sva_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o, .frame_start_i, .line_end_i, .master_activity_i,
  .prot_master_bus_free_o, .av_mute_o, .encrypt_o, .blue_screen_o, .auth_tick_o,
  .checksum_valid_o, .ri_check_o, .ri_sync_check_o, .pj_check_o);

// ===== dv/cpt_rx_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Far receiver: detect, lock and bus signalling levels
// ------------------------------------------------------------
module cpt_rx_model (
  input  wire logic clk_i,
  input  wire logic present_i,
  input  wire logic locked_i,
  input  wire logic talk_i,
  output logic      rx_detect_o,
  output logic      rx_lock_o,
  output logic      activity_o
);
  // A receiver that is absent can never report lock.
  always_ff @(posedge clk_i) begin
    rx_detect_o <= present_i;
    rx_lock_o   <= present_i & locked_i;
    activity_o  <= talk_i;
  end
endmodule

// ===== logic/cpt_config.sv
// Summary of operation
// - Master frees bus after 1 s idle
// - Ri checked around frame 128, sync at 127
// - Send per-channel ones-complement line checksums
// - Test bit shortens Pj and Ri periods
// - Accelerate bit speeds authentication timers
// - Fast bit selects master timing, mirrored
// - Enhanced verify checks Pj every 16th frame
// - Select bit chooses EESS or OESS signalling
// - Repeater bit enables repeater authentication
// - Mode field picks one of four modes
// - Mode resets from repeater strap
// - Wait bit inserts 100 ms wait
// - Qualify bit adds lock to detect interrupt
// - Mute bit freezes encryption status controls
// - Always-encrypt makes enable read as one
// - Enabled, unauthenticated sends blue screen, except in authenticated mode
`timescale 1ns/1ps
module cpt_config #(
  parameter int unsigned BUS_IDLE_CYC = cpt_pkg::BUS_IDLE_CYC,
  parameter int unsigned TICK_CYC     = cpt_pkg::TICK_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        strap_repeater_i,
  input  wire logic        authenticated_i,
  input  wire logic        frame_start_i,
  input  wire logic        in_band_encrypt_i,
  input  wire logic        pixel_valid_i,
  input  wire logic [23:0] pixel_rgb_i,
  input  wire logic        line_end_i,
  input  wire logic        master_activity_i,
  input  wire logic        wait_start_i,
  input  wire logic        rx_detect_i,
  input  wire logic        rx_lock_i,
  output logic             irq_o,
  output logic             prot_master_fast_timing_o,
  output logic             prot_master_bus_free_o,
  output logic             status_signalling_select_o,
  output logic             transmit_repeater_enable_o,
  output logic             av_mute_o,
  output logic             encrypt_o,
  output logic             blue_screen_o,
  output logic             auth_tick_o,
  output logic             wait_done_o,
  output logic             checksum_valid_o,
  output logic      [23:0] checksum_rgb_o,
  output logic             ri_check_o,
  output logic             ri_sync_check_o,
  output logic             pj_check_o
);

  typedef struct packed {
    logic [7:0]                dbg;
    logic [7:0]                cfg;
    logic                      cipher_en;
    logic                      ack;
    logic [31:0]               dat;
    logic                      strap_s1;
    logic                      strap_s2;
    logic [1:0]                boot;
    logic [3:0]                irq_st;
    logic [3:0]                irq_mask;
    logic                      irq;
    logic [31:0]               idle_cnt;
    logic                      bus_free;
    logic [31:0]               tick_cnt;
    logic                      tick;
    cpt_pkg::cpt_wait_state_t  wstate;
    logic [6:0]                wait_cnt;
    logic                      wait_done;
    logic [23:0]               sum;
    logic                      ck_valid;
    logic [23:0]               ck;
    logic                      inband;
    logic                      encrypt;
    logic                      blue;
    logic                      det_q;
  } cpt_state_t;

  cpt_state_t            s;
  cpt_state_t            next_s;
  logic       [23:0]     acc;
  logic       [7:0]      idx;
  logic       [7:0]      rdata;
  logic                  req;
  logic                  wr;
  logic                  enc;
  logic                  blue;
  logic                  det;
  logic       [31:0]     tick_lim;
  logic       [3:0]      events;
  cpt_pkg::cpt_enc_mode_t mode;

  // ------------------------------------------------------------
  // Line checksum adders, one per colour channel
  // ------------------------------------------------------------
  for (genvar i = 0; i < 3; i++) begin : g_ch
    logic [8:0] raw;
    assign raw = {1'b0, s.sum[8*i +: 8]} + {1'b0, pixel_rgb_i[8*i +: 8]};
    // End-around carry keeps the sum in ones-complement form.
    assign acc[8*i +: 8] = pixel_valid_i ? raw[7:0] + {7'h00, raw[8]}
                                         : s.sum[8*i +: 8];
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    next_s = s;
    events = 4'h0;
    idx    = wb_adr_i[9:2];
    req    = wb_cyc_i && wb_stb_i;
    // Writes commit on the edge where the master sees ack.
    wr     = req && wb_we_i && s.ack && wb_sel_i[0];
    mode   = cpt_pkg::cpt_enc_mode_t'(s.cfg[cpt_pkg::CFG_MODE_LO +: 2]);

    // Strap passes two flops; it is read only once both are loaded.
    next_s.strap_s1 = strap_repeater_i;
    next_s.strap_s2 = s.strap_s1;
    if (s.boot != 2'h3) begin
      next_s.boot = s.boot + 2'h1;
    end

    // Register read data.
    case (idx)
      cpt_pkg::IDX_DEBUG: begin
        rdata = s.dbg & cpt_pkg::DEBUG_WMASK;
      end
      cpt_pkg::IDX_CONFIG: begin
        rdata = s.cfg;
      end
      cpt_pkg::IDX_CTRL: begin
        rdata = {7'h00, (mode == cpt_pkg::CPT_ENC_ALWAYS) | s.cipher_en};
      end
      cpt_pkg::IDX_STATUS: begin
        rdata = {2'h0, s.bus_free, s.det_q, s.blue, s.encrypt,
                 authenticated_i, s.dbg[cpt_pkg::DBG_FAST]};
      end
      cpt_pkg::IDX_IRQ_STAT: begin
        rdata = {4'h0, s.irq_st};
      end
      cpt_pkg::IDX_IRQ_MASK: begin
        rdata = {4'h0, s.irq_mask};
      end
      default: begin
        rdata = 8'h00;
      end
    endcase

    // Bus handshake: one wait state, then ack for one cycle.
    next_s.ack = req && !s.ack;
    if (req && !s.ack) begin
      next_s.dat = {24'h000000, rdata};
    end

    // Register writes.
    if (wr) begin
      case (idx)
        cpt_pkg::IDX_DEBUG: begin
          next_s.dbg = wb_dat_i[7:0] & cpt_pkg::DEBUG_WMASK;
        end
        cpt_pkg::IDX_CONFIG: begin
          next_s.cfg = wb_dat_i[7:0];
        end
        cpt_pkg::IDX_CTRL: begin
          if (mode != cpt_pkg::CPT_ENC_ALWAYS) begin
            next_s.cipher_en = wb_dat_i[0];
          end
        end
        cpt_pkg::IDX_IRQ_MASK: begin
          next_s.irq_mask = wb_dat_i[3:0];
        end
        default: begin
        end
      endcase
    end

    // Power-up mode follows the repeater strap.
    if (s.boot == cpt_pkg::BOOT_LOAD) begin
      next_s.cfg[cpt_pkg::CFG_MODE_LO +: 2] = s.strap_s2 ? cpt_pkg::CPT_ENC_IN_BAND
                                                         : cpt_pkg::CPT_ENC_AUTHENTICATED;
    end

    // Bus idle timeout of the embedded master.
    next_s.bus_free = 1'b0;
    if (master_activity_i || s.dbg[cpt_pkg::DBG_TIMEOUT_DIS]) begin
      next_s.idle_cnt = 32'h0;
    end else if (s.idle_cnt != BUS_IDLE_CYC) begin
      next_s.idle_cnt = s.idle_cnt + 32'h1;
    end else begin
      next_s.bus_free = 1'b1;
    end
    events[cpt_pkg::IRQ_BUS_FREE] = next_s.bus_free && !s.bus_free;

    // Authentication timer tick.
    tick_lim = s.dbg[cpt_pkg::DBG_ACCEL] ? cpt_pkg::TICK_FAST_CYC : TICK_CYC;
    next_s.tick = 1'b0;
    if (wait_start_i || s.tick_cnt >= tick_lim - 32'h1) begin
      next_s.tick_cnt = 32'h0;
      next_s.tick     = !wait_start_i;
    end else begin
      next_s.tick_cnt = s.tick_cnt + 32'h1;
    end

    // Optional receiver settling wait, counted in timer ticks.
    next_s.wait_done = 1'b0;
    case (s.wstate)
      cpt_pkg::CPT_WAIT_IDLE: begin
        if (wait_start_i) begin
          if (s.cfg[cpt_pkg::CFG_WAIT_EN]) begin
            next_s.wstate   = cpt_pkg::CPT_WAIT_RUN;
            next_s.wait_cnt = 7'h00;
          end else begin
            next_s.wait_done = 1'b1;
          end
        end
      end
      cpt_pkg::CPT_WAIT_RUN: begin
        if (s.tick) begin
          if (s.wait_cnt == 7'(cpt_pkg::WAIT_MS - 1)) begin
            next_s.wait_done = 1'b1;
            next_s.wstate    = cpt_pkg::CPT_WAIT_IDLE;
          end else begin
            next_s.wait_cnt = s.wait_cnt + 7'h01;
          end
        end
      end
      default: begin
        next_s.wstate = cpt_pkg::CPT_WAIT_IDLE;
      end
    endcase
    events[cpt_pkg::IRQ_WAIT_DONE] = next_s.wait_done;

    // Line checksum.
    next_s.ck_valid = 1'b0;
    if (line_end_i) begin
      next_s.sum = 24'h000000;
      if (s.dbg[cpt_pkg::DBG_CHECKSUM]) begin
        next_s.ck_valid = 1'b1;
        next_s.ck       = ~acc;
      end
    end else begin
      next_s.sum = acc;
    end

    // Encryption decision.
    if (frame_start_i) begin
      next_s.inband = in_band_encrypt_i;
    end
    case (mode)
      cpt_pkg::CPT_ENC_AUTHENTICATED: begin
        enc  = authenticated_i;
        blue = 1'b0;
      end
      cpt_pkg::CPT_ENC_REGISTER: begin
        enc  = s.cipher_en && authenticated_i;
        blue = s.cipher_en && !authenticated_i;
      end
      cpt_pkg::CPT_ENC_ALWAYS: begin
        enc  = authenticated_i;
        blue = !authenticated_i;
      end
      default: begin
        enc  = s.inband && authenticated_i;
        blue = s.inband && !authenticated_i;
      end
    endcase
    // While muted the controls are ignored and the last status holds.
    if (!s.cfg[cpt_pkg::CFG_MUTE]) begin
      next_s.encrypt = enc;
      next_s.blue    = blue;
    end

    // Receiver detect, optionally qualified by lock.
    det = rx_detect_i && (!s.cfg[cpt_pkg::CFG_RXDET_QUAL] || rx_lock_i);
    next_s.det_q = det;
    events[cpt_pkg::IRQ_RX_DETECT] = det && !s.det_q;
    events[cpt_pkg::IRQ_LINK_CHECK] = ri_check_o || ri_sync_check_o || pj_check_o;

    // Sticky status: a new event wins over a same-cycle clear.
    if (wr && idx == cpt_pkg::IDX_IRQ_STAT) begin
      next_s.irq_st = s.irq_st & ~wb_dat_i[3:0];
    end
    next_s.irq_st = next_s.irq_st | events;
    next_s.irq    = |(next_s.irq_st & next_s.irq_mask);
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s        <= '0;
      s.dbg    <= cpt_pkg::DEBUG_RST;
      s.cfg    <= cpt_pkg::CONFIG_RST;
      s.wstate <= cpt_pkg::CPT_WAIT_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------
  // Frame scheduling of link checks
  // ------------------------------------------------------------
  cpt_frame_sched u_sched (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .frame_start_i   (frame_start_i),
    .fc_test_i       (s.dbg[cpt_pkg::DBG_FC_TEST]),
    .sync_dis_i      (s.dbg[cpt_pkg::DBG_SYNC_DIS]),
    .pj_enable_i     (s.cfg[cpt_pkg::CFG_LINK_VERIFY]),
    .ri_check_o      (ri_check_o),
    .ri_sync_check_o (ri_sync_check_o),
    .pj_check_o      (pj_check_o)
  );

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign wb_dat_o                   = s.dat;
  assign wb_ack_o                   = s.ack;
  assign irq_o                      = s.irq;
  assign prot_master_fast_timing_o  = s.dbg[cpt_pkg::DBG_FAST];
  assign prot_master_bus_free_o     = s.bus_free;
  assign status_signalling_select_o = s.cfg[cpt_pkg::CFG_SIG_SEL];
  assign transmit_repeater_enable_o = s.cfg[cpt_pkg::CFG_REPEATER];
  assign av_mute_o                  = s.cfg[cpt_pkg::CFG_MUTE];
  assign encrypt_o                  = s.encrypt;
  assign blue_screen_o              = s.blue;
  assign auth_tick_o                = s.tick;
  assign wait_done_o                = s.wait_done;
  assign checksum_valid_o           = s.ck_valid;
  assign checksum_rgb_o             = s.ck;

endmodule

// ===== logic/cpt_frame_sched.sv
`timescale 1ns/1ps
module cpt_frame_sched (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic frame_start_i,
  input  wire logic fc_test_i,
  input  wire logic sync_dis_i,
  input  wire logic pj_enable_i,
  output logic      ri_check_o,
  output logic      ri_sync_check_o,
  output logic      pj_check_o
);

  typedef struct packed {
    logic [6:0] cnt;
    logic       ri;
    logic       sync;
    logic       pj;
  } cpt_sched_t;

  cpt_sched_t s;
  cpt_sched_t next_s;
  logic [6:0] ri_mask;
  logic [6:0] pj_mask;
  logic [6:0] nxt_cnt;

  // ------------------------------------------------------------
  // Frame counter
  // ------------------------------------------------------------
  always_comb begin
    ri_mask = fc_test_i ? cpt_pkg::RI_MASK_TEST : cpt_pkg::RI_MASK;
    pj_mask = fc_test_i ? cpt_pkg::PJ_MASK_TEST : cpt_pkg::PJ_MASK;
    nxt_cnt = (s.cnt + 7'h01) & ri_mask;
    next_s      = s;
    next_s.ri   = 1'b0;
    next_s.sync = 1'b0;
    next_s.pj   = 1'b0;
    if (frame_start_i) begin
      next_s.cnt  = nxt_cnt;
      // Wrap marks the frame after the period; the frame before it is the sync check.
      next_s.ri   = (nxt_cnt == 7'h00);
      next_s.sync = (nxt_cnt == ri_mask) && !sync_dis_i;
      next_s.pj   = pj_enable_i && ((nxt_cnt & pj_mask) == 7'h00);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign ri_check_o      = s.ri;
  assign ri_sync_check_o = s.sync;
  assign pj_check_o      = s.pj;

endmodule

// ===== logic/cpt_pkg.sv
package cpt_pkg;

  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned BUS_IDLE_S    = 1;
  localparam int unsigned BUS_IDLE_CYC  = BUS_IDLE_S * CLK_HZ;
  localparam int unsigned TICK_US       = 1000;
  localparam int unsigned TICK_CYC      = TICK_US * (CLK_HZ / 1_000_000);
  localparam int unsigned TICK_FAST_CYC = 125;
  localparam int unsigned WAIT_MS       = 100;
  localparam int unsigned RI_PERIOD      = 128;
  localparam int unsigned RI_PERIOD_TEST = 16;
  localparam int unsigned PJ_PERIOD      = 16;
  localparam int unsigned PJ_PERIOD_TEST = 2;
  localparam logic [6:0]  RI_MASK      = 7'(RI_PERIOD - 1);
  localparam logic [6:0]  RI_MASK_TEST = 7'(RI_PERIOD_TEST - 1);
  localparam logic [6:0]  PJ_MASK      = 7'(PJ_PERIOD - 1);
  localparam logic [6:0]  PJ_MASK_TEST = 7'(PJ_PERIOD_TEST - 1);
  localparam logic [1:0]  BOOT_LOAD    = 2'h2;

  // ------------------------------------------------------------
  // Register map (word index, byte address is four times it)
  // ------------------------------------------------------------
  localparam int unsigned ADR_W        = 10;
  localparam logic [7:0]  IDX_DEBUG    = 8'hC0;
  localparam logic [7:0]  IDX_CONFIG   = 8'hC2;
  localparam logic [7:0]  IDX_CTRL     = 8'hC8;
  localparam logic [7:0]  IDX_STATUS   = 8'hC9;
  localparam logic [7:0]  IDX_IRQ_STAT = 8'hCA;
  localparam logic [7:0]  IDX_IRQ_MASK = 8'hCB;
  localparam logic [7:0]  DEBUG_RST    = 8'h00;
  localparam logic [7:0]  CONFIG_RST   = 8'h80;
  localparam logic [7:0]  DEBUG_WMASK  = 8'h5F;

  // Debug register fields.
  localparam int unsigned DBG_TIMEOUT_DIS = 6;
  localparam int unsigned DBG_SYNC_DIS    = 4;
  localparam int unsigned DBG_CHECKSUM    = 3;
  localparam int unsigned DBG_FC_TEST     = 2;
  localparam int unsigned DBG_ACCEL       = 1;
  localparam int unsigned DBG_FAST        = 0;

  // Config register fields.
  localparam int unsigned CFG_LINK_VERIFY = 7;
  localparam int unsigned CFG_SIG_SEL     = 6;
  localparam int unsigned CFG_REPEATER    = 5;
  localparam int unsigned CFG_MODE_LO     = 3;
  localparam int unsigned CFG_WAIT_EN     = 2;
  localparam int unsigned CFG_RXDET_QUAL  = 1;
  localparam int unsigned CFG_MUTE        = 0;

  // Interrupt status and mask bits.
  localparam int unsigned IRQ_W          = 4;
  localparam int unsigned IRQ_RX_DETECT  = 0;
  localparam int unsigned IRQ_BUS_FREE   = 1;
  localparam int unsigned IRQ_WAIT_DONE  = 2;
  localparam int unsigned IRQ_LINK_CHECK = 3;

  typedef enum logic [1:0] {
    CPT_ENC_AUTHENTICATED = 2'b00,
    CPT_ENC_REGISTER      = 2'b01,
    CPT_ENC_ALWAYS        = 2'b10,
    CPT_ENC_IN_BAND       = 2'b11
  } cpt_enc_mode_t;

  typedef enum logic {
    CPT_WAIT_IDLE = 1'b0,
    CPT_WAIT_RUN  = 1'b1
  } cpt_wait_state_t;

endpackage
